// ==== aux_relay_ctrl.v ====
`timescale 1ns/1ns
`default_nettype none
`include "aux_relay_map.vh"
module aux_relay_ctrl #(
  parameter NUM_RELAY   = 12,
  parameter NUM_EXP_IN  = 8,
  parameter STEP_CYCLES = `STEP_CYCLES
) (
  // clock and reset
  input  wire                     mclk_i,
  input  wire                     srst_i,
  // mode
  input  wire                     remote_mode_i,
  // auxiliary inputs, classified by the comparator stage
  input  wire [1:0]               aux_class_a_i,
  input  wire [1:0]               aux_class_b_i,
  input  wire                     aux_nc_a_i,
  input  wire                     aux_nc_b_i,
  input  wire [1:0]               aux_sup_a_i,
  input  wire [1:0]               aux_sup_b_i,
  input  wire [4:0]               filter_steps_i,
  // input expansion card
  input  wire [NUM_EXP_IN-1:0]    input_expansion_card_i,
  // clutter
  input  wire [7:0]               clutter_a_i,
  input  wire [7:0]               clutter_b_i,
  input  wire [7:0]               hist_clutter_a_i,
  input  wire [7:0]               hist_clutter_b_i,
  input  wire [7:0]               hist_var_i,
  // local conditions
  input  wire                     zone_alarm_i,
  input  wire                     sup_a_i,
  input  wire                     sup_b_i,
  input  wire                     enc_tamper_i,
  input  wire                     dc_fail_i,
  input  wire                     bat_present_i,
  input  wire                     bat_charged_i,
  input  wire                     bat_low_i,
  input  wire                     hw_fault_i,
  // relay configuration
  input  wire [NUM_RELAY*8-1:0]   cond_mask_i,
  input  wire [NUM_RELAY-1:0]     side_a_map_i,
  input  wire [NUM_RELAY-1:0]     side_b_map_i,
  input  wire [NUM_RELAY-1:0]     zone_map_i,
  input  wire [NUM_RELAY-1:0]     fail_safe_i,
  input  wire [NUM_RELAY*2-1:0]   act_type_i,
  input  wire [NUM_RELAY*5-1:0]   on_steps_i,
  input  wire [NUM_RELAY*5-1:0]   off_steps_i,
  // host commands
  input  wire [NUM_RELAY-1:0]     host_on_i,
  input  wire [NUM_RELAY-1:0]     host_off_i,
  // status to host
  output reg                      change_o,
  output reg  [NUM_EXP_IN+1:0]    input_state_o,
  output reg  [1:0]               aux_tamper_o,
  output reg  [1:0]               test_pass_o,
  output reg  [1:0]               test_fail_o,
  output reg                      power_lost_o,
  // relays
  output wire [NUM_RELAY-1:0]     relay_o
);
  // ***********************************
  // step tick, 125 ms
  // ***********************************
  reg [23:0] div_q;
  reg        tick_q;
  always @(posedge mclk_i) begin
    if (srst_i) begin
      div_q  <= 24'h000000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == STEP_CYCLES[23:0] - 24'h000001);
      if (div_q == STEP_CYCLES[23:0] - 24'h000001)
        div_q <= 24'h000000;
      else
        div_q <= div_q + 24'h000001;
    end
  end

  // ***********************************
  // input interpretation
  // ***********************************
  // open-circuit in a supervised loop shows as tamper from the comparator
  reg [1:0] act_raw;
  reg [1:0] tamp_raw;
  always @* begin
    tamp_raw[0] = (aux_sup_a_i != `SUP_NONE) && (aux_class_a_i == `CLS_TAMPER);
    tamp_raw[1] = (aux_sup_b_i != `SUP_NONE) && (aux_class_b_i == `CLS_TAMPER);
    act_raw[0]  = (aux_class_a_i == `CLS_ALARM) ^ (aux_nc_a_i && aux_sup_a_i == `SUP_NONE);
    act_raw[1]  = (aux_class_b_i == `CLS_ALARM) ^ (aux_nc_b_i && aux_sup_b_i == `SUP_NONE);
  end

  // ***********************************
  // filter window
  // ***********************************
  reg [4:0] filt_q [0:1];
  reg [1:0] filt_act_q;
  reg [1:0] filt_prev_q;
  reg [4:0] fwin;
  integer   i;
  always @* begin
    fwin = (filter_steps_i > `STEP_MAX) ? `STEP_MAX : filter_steps_i;
  end
  always @(posedge mclk_i) begin
    if (srst_i) begin
      filt_q[0]   <= 5'h00;
      filt_q[1]   <= 5'h00;
      filt_act_q  <= 2'h0;
      filt_prev_q <= 2'h0;
    end else begin
      filt_prev_q <= filt_act_q;
      for (i = 0; i < 2; i = i + 1) begin
        if (!act_raw[i]) begin
          filt_q[i]     <= 5'h00;
          filt_act_q[i] <= 1'b0;
        end else if (filt_q[i] >= fwin) begin
          filt_act_q[i] <= 1'b1;
        end else if (tick_q) begin
          filt_q[i] <= filt_q[i] + 5'h01;
        end
      end
    end
  end

  // ***********************************
  // self-test and status reporting
  // ***********************************
  wire [1:0] rise = filt_act_q & ~filt_prev_q;
  wire [7:0] dev_a = (clutter_a_i > hist_clutter_a_i) ? clutter_a_i - hist_clutter_a_i
                                                       : hist_clutter_a_i - clutter_a_i;
  wire [7:0] dev_b = (clutter_b_i > hist_clutter_b_i) ? clutter_b_i - hist_clutter_b_i
                                                       : hist_clutter_b_i - clutter_b_i;
  wire       ok_a  = (dev_a <= hist_var_i);
  wire       ok_b  = (dev_b <= hist_var_i);
  wire [NUM_EXP_IN+1:0] state_now = {input_expansion_card_i, filt_act_q};
  wire       power_lost = dc_fail_i && (!bat_present_i || !bat_charged_i || bat_low_i);
  reg  [1:0] test_hold_q;
  always @(posedge mclk_i) begin
    if (srst_i) begin
      change_o      <= 1'b0;
      input_state_o <= {(NUM_EXP_IN+2){1'b0}};
      aux_tamper_o  <= 2'h0;
      test_pass_o   <= 2'h0;
      test_fail_o   <= 2'h0;
      test_hold_q   <= 2'h0;
      power_lost_o  <= 1'b0;
    end else begin
      power_lost_o  <= power_lost;
      aux_tamper_o  <= tamp_raw;
      input_state_o <= state_now;
      change_o      <= remote_mode_i && (state_now != input_state_o);
      test_pass_o   <= {2{!remote_mode_i}} & rise & {ok_b, ok_a};
      test_fail_o   <= {2{!remote_mode_i}} & rise & ~{ok_b, ok_a};
      // keep the side request up while the test input stays held
      test_hold_q   <= {2{!remote_mode_i}} & filt_act_q &
                       ({ok_b, ok_a} & (rise | test_hold_q));
    end
  end

  // ***********************************
  // relay activation conditions
  // ***********************************
  wire [7:0] cond_vec;
  assign cond_vec[`COND_ZONE]     = zone_alarm_i;
  assign cond_vec[`COND_SUP_A]    = sup_a_i;
  assign cond_vec[`COND_SUP_B]    = sup_b_i;
  assign cond_vec[`COND_TAMPER]   = enc_tamper_i;
  assign cond_vec[`COND_DC_FAIL]  = dc_fail_i;
  assign cond_vec[`COND_BAT_FAIL] = bat_present_i && bat_low_i;
  assign cond_vec[`COND_HW_FAULT] = hw_fault_i;
  assign cond_vec[`COND_FAILSAFE] = power_lost;

  genvar g;
  generate
    for (g = 0; g < NUM_RELAY; g = g + 1) begin : relay_gen
      wire req = (|(cond_mask_i[g*8 +: 8] & cond_vec)) ||
                 (zone_map_i[g] && zone_alarm_i) ||
                 (side_a_map_i[g] && test_hold_q[0]) ||
                 (side_b_map_i[g] && test_hold_q[1]);
      relay_channel u_ch (
        .mclk_i         (mclk_i),
        .srst_i         (srst_i),
        .tick_i         (tick_q),
        .remote_i       (remote_mode_i),
        .local_req_i    (req),
        .act_type_i     (act_type_i[g*2 +: 2]),
        .on_steps_i     (on_steps_i[g*5 +: 5]),
        .off_steps_i    (off_steps_i[g*5 +: 5]),
        .cmd_on_i       (host_on_i[g]),
        .cmd_off_i      (host_off_i[g]),
        .fail_safe_en_i (fail_safe_i[g]),
        .power_lost_i   (power_lost),
        .relay_o        (relay_o[g])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// ==== aux_relay_ctrl_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "aux_relay_map.vh"
module aux_relay_ctrl_tb_top;
  // ****************
  // bench
  // ****************
  logic        mclk_i, srst_i, remote_mode_i, aux_nc_a_i, aux_nc_b_i, zone_alarm_i, sup_a_i;
  logic        sup_b_i, enc_tamper_i, dc_fail_i, bat_present_i, bat_charged_i, bat_low_i;
  logic        hw_fault_i, change_o, power_lost_o, last;
  logic [1:0]  aux_class_a_i, aux_class_b_i, aux_sup_a_i, aux_sup_b_i;
  logic [1:0]  aux_tamper_o, test_pass_o, test_fail_o;
  logic [4:0]  filter_steps_i;
  logic [7:0]  input_expansion_card_i, clutter_a_i, clutter_b_i;
  logic [7:0]  hist_clutter_a_i, hist_clutter_b_i, hist_var_i;
  logic [9:0]  input_state_o;
  logic [11:0] side_a_map_i, side_b_map_i, zone_map_i, fail_safe_i;
  logic [11:0] host_on_i, host_off_i, relay_o;
  logic [23:0] act_type_i;
  logic [59:0] on_steps_i, off_steps_i;
  logic [95:0] cond_mask_i;
  integer      err_count = 0, n_checks = 0, toggles = 0;
  logic [1:0]  pass_seen, fail_seen;
  // short step keeps the run brief; tick and cmd waits below are counted in clock cycles, 10 per step
  aux_relay_ctrl #(.STEP_CYCLES(10)) u_dut (
    .mclk_i(mclk_i), .srst_i(srst_i), .remote_mode_i(remote_mode_i),
    .aux_class_a_i(aux_class_a_i), .aux_class_b_i(aux_class_b_i),
    .aux_nc_a_i(aux_nc_a_i), .aux_nc_b_i(aux_nc_b_i),
    .aux_sup_a_i(aux_sup_a_i), .aux_sup_b_i(aux_sup_b_i), .filter_steps_i(filter_steps_i),
    .input_expansion_card_i(input_expansion_card_i),
    .clutter_a_i(clutter_a_i), .clutter_b_i(clutter_b_i),
    .hist_clutter_a_i(hist_clutter_a_i), .hist_clutter_b_i(hist_clutter_b_i),
    .hist_var_i(hist_var_i), .zone_alarm_i(zone_alarm_i), .sup_a_i(sup_a_i),
    .sup_b_i(sup_b_i), .enc_tamper_i(enc_tamper_i), .dc_fail_i(dc_fail_i),
    .bat_present_i(bat_present_i), .bat_charged_i(bat_charged_i), .bat_low_i(bat_low_i),
    .hw_fault_i(hw_fault_i), .cond_mask_i(cond_mask_i), .side_a_map_i(side_a_map_i),
    .side_b_map_i(side_b_map_i), .zone_map_i(zone_map_i), .fail_safe_i(fail_safe_i),
    .act_type_i(act_type_i), .on_steps_i(on_steps_i), .off_steps_i(off_steps_i),
    .host_on_i(host_on_i), .host_off_i(host_off_i), .change_o(change_o),
    .input_state_o(input_state_o), .aux_tamper_o(aux_tamper_o),
    .test_pass_o(test_pass_o), .test_fail_o(test_fail_o),
    .power_lost_o(power_lost_o), .relay_o(relay_o));
  // self-test verdicts are one-cycle pulses, so keep what has been seen
  always @(posedge mclk_i) begin
    if (srst_i) begin
      pass_seen <= 2'h0;
      fail_seen <= 2'h0;
    end else begin
      pass_seen <= pass_seen | test_pass_o;
      fail_seen <= fail_seen | test_fail_o;
    end
  end
  relay_host_model u_host (.mclk_i(mclk_i), .change_i(change_o), .host_on_o(host_on_i),
                           .host_off_o(host_off_i));
  initial begin
    mclk_i = 1'h0;
    forever #20 mclk_i = ~mclk_i;
  end
  task tick(input integer n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #80000;
    err_count = err_count + 1;
    $display("ERROR watchdog expected tests done seen timeout");
    final_report;
  end
  initial begin
    {srst_i, remote_mode_i, bat_present_i} = 3'h7;
    {aux_nc_a_i, aux_nc_b_i, zone_alarm_i, sup_a_i, sup_b_i, enc_tamper_i} = 6'h00;
    {dc_fail_i, bat_charged_i, bat_low_i, hw_fault_i} = 4'h0;
    {aux_class_a_i, aux_class_b_i, aux_sup_a_i, aux_sup_b_i} = 8'h00;
    {filter_steps_i, hist_var_i, input_expansion_card_i} = {5'h02, 8'h0C, 8'h00};
    {clutter_a_i, hist_clutter_a_i, clutter_b_i, hist_clutter_b_i} = 32'h323A_6032;
    {side_a_map_i, side_b_map_i, zone_map_i, fail_safe_i} = 48'h008_020_010_080;
    {act_type_i, on_steps_i, off_steps_i} = {24'h000024, 60'h10821, 60'h20};
    cond_mask_i = 96'h0048_0001_0000_0000;
    tick(6);
    srst_i = 1'h0;
    chk("relays after reset", 12'h000, relay_o);
    u_host.cmd(1'h1, 0);
    tick(30);
    chk("latch held", 12'h001, relay_o);
    u_host.cmd(1'h0, 0);
    tick(3);
    chk("latch off", 12'h000, relay_o);
    u_host.cmd(1'h1, 2);
    tick(3);
    chk("pulse on", 12'h004, relay_o);
    tick(35);
    chk("pulse ended", 12'h000, relay_o);
    u_host.cmd(1'h1, 1);
    repeat (80) begin
      last = relay_o[1];
      tick(1);
      if (relay_o[1] !== last) toggles = toggles + 1;
    end
    chk("flash toggles", 12'h001, {11'h0, toggles > 2});
    u_host.cmd(1'h0, 1);
    tick(3);
    chk("flash off", 12'h000, relay_o);
    $display("test remote relays done");
    repeat (3) begin
      aux_class_a_i = `CLS_ALARM;
      tick(8);
      aux_class_a_i = `CLS_NORMAL;
      tick(1);
    end
    chk("short input", 12'h000, input_state_o);
    {aux_class_a_i, input_expansion_card_i} = {`CLS_ALARM, 8'h01};
    tick(40);
    chk("input state", 12'h005, input_state_o);
    chk("change sent", 12'h001, {11'h0, u_host.n_change > 0});
    {aux_class_a_i, input_expansion_card_i, aux_nc_a_i} = {`CLS_NORMAL, 8'h00, 1'h1};
    {aux_sup_b_i, aux_class_b_i} = {`SUP_SINGLE, `CLS_TAMPER};
    tick(40);
    chk("nc input", 12'h001, input_state_o & 10'h001);
    chk("tamper", 12'h002, aux_tamper_o);
    {aux_nc_a_i, aux_sup_b_i, aux_class_b_i} = {1'h0, `SUP_NONE, `CLS_NORMAL};
    tick(40);
    $display("test remote inputs done");
    remote_mode_i = 1'h0;
    aux_class_a_i = `CLS_ALARM;
    tick(40);
    chk("side a test", 12'h008, relay_o);
    chk("side a verdict", 12'h001, {8'h00, fail_seen, pass_seen});
    aux_class_a_i = `CLS_NORMAL;
    tick(8);
    chk("active time", 12'h008, relay_o);
    tick(27);
    aux_class_b_i = `CLS_ALARM;
    tick(40);
    chk("side b fails", 12'h000, relay_o);
    chk("side b verdict", 12'h009, {8'h00, fail_seen, pass_seen});
    aux_class_b_i = `CLS_NORMAL;
    u_host.cmd(1'h1, 0);
    tick(3);
    chk("host in local", 12'h000, relay_o);
    {zone_alarm_i, enc_tamper_i} = 2'h3;
    tick(5);
    chk("zone and tamper", 12'h050, relay_o);
    {zone_alarm_i, enc_tamper_i, remote_mode_i} = 3'h1;
    tick(30);
    zone_alarm_i = 1'h1;
    tick(5);
    chk("local in remote", 12'h000, relay_o);
    {zone_alarm_i, remote_mode_i, dc_fail_i, bat_present_i} = 4'h2;
    tick(5);
    chk("fail safe", 12'h081, {relay_o[11:1], power_lost_o});
    {bat_present_i, bat_charged_i} = 2'h3;
    tick(5);
    chk("battery holds", 12'h000, {11'h0, power_lost_o});
    $display("test local relays done");
    final_report;
  end
endmodule
bind aux_relay_ctrl aux_relay_monitor u_mon (
  .mclk_i(mclk_i), .srst_i(srst_i), .remote_mode_i(remote_mode_i),
  .clutter_a_i(clutter_a_i), .hist_clutter_a_i(hist_clutter_a_i), .hist_var_i(hist_var_i),
  .dc_fail_i(dc_fail_i), .bat_present_i(bat_present_i), .fail_safe_i(fail_safe_i),
  .host_on_i(host_on_i), .host_off_i(host_off_i), .change_o(change_o),
  .input_state_o(input_state_o), .test_pass_o(test_pass_o), .test_fail_o(test_fail_o),
  .power_lost_o(power_lost_o), .relay_o(relay_o));
`default_nettype wire

// ==== aux_relay_map.vh ====
// Summary of operation
// - inputs configurable NO/NC and supervision type
// - event only after filter window held
// - local mode inputs trigger side A/B tests
// - clutter within variance fires side relays
// - clutter outside variance leaves relays off
// - remote mode reports every input change
// - local mode device drives on-board relays
// - relay on for event plus active time
// - per-relay condition masks activate relay
// - expansion relays may follow zone alarms
// - fail-safe relays alarm on power loss
// - power loss is DC fail with battery absent, uncharged or low
// - remote mode relays follow host commands
// - latching relay on until off command
// - flash relay toggles until off command
// - pulse relay on for period then off
// - flash/pulse durations from per-relay config
// - filter window 0 to 2.5 s, 125 ms steps
// - flash off time 125 ms to 3.875 s, 125 ms steps
`ifndef AUX_RELAY_MAP_VH
`define AUX_RELAY_MAP_VH
`define CLK_HZ          25000000
`define STEP_MS         125
`define STEP_CYCLES     ((`CLK_HZ / 1000) * `STEP_MS)
`define STEP_MAX        5'h14
`define FILTER_DEFAULT  5'h02
`define ACTIVE_DEFAULT  5'h10
`define VAR_DEFAULT     8'h0C
`define SUP_NONE        2'h0
`define SUP_SINGLE      2'h1
`define SUP_DUAL        2'h2
`define CLS_NORMAL      2'h0
`define CLS_ALARM       2'h1
`define CLS_TAMPER      2'h2
`define ACT_LATCH       2'h0
`define ACT_FLASH       2'h1
`define ACT_PULSE       2'h2
`define NUM_COND        8
`define COND_ZONE       0
`define COND_SUP_A      1
`define COND_SUP_B      2
`define COND_TAMPER     3
`define COND_DC_FAIL    4
`define COND_BAT_FAIL   5
`define COND_HW_FAULT   6
`define COND_FAILSAFE   7
`endif

// ==== aux_relay_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "aux_relay_map.vh"
module aux_relay_monitor (
  // clock, reset, mode
  input wire        mclk_i,
  input wire        srst_i,
  input wire        remote_mode_i,
  // stimulus
  input wire [7:0]  clutter_a_i,
  input wire [7:0]  hist_clutter_a_i,
  input wire [7:0]  hist_var_i,
  input wire        dc_fail_i,
  input wire        bat_present_i,
  input wire [11:0] fail_safe_i,
  input wire [11:0] host_on_i,
  input wire [11:0] host_off_i,
  // outputs
  input wire        change_o,
  input wire [9:0]  input_state_o,
  input wire [1:0]  test_pass_o,
  input wire [1:0]  test_fail_o,
  input wire        power_lost_o,
  input wire [11:0] relay_o
);
  // ****************
  // checks
  // ****************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // nine-bit sums so a large variance cannot wrap
  wire [8:0] hi_a = hist_clutter_a_i + hist_var_i;
  wire [8:0] lo_a = clutter_a_i + hist_var_i;
  wire       ok_a = ({1'h0, clutter_a_i} <= hi_a) && ({1'h0, hist_clutter_a_i} <= lo_a);
  a_host_on: assert property (
    remote_mode_i && host_on_i[0] && !host_off_i[0] |-> ##2 relay_o[0]) else $error("on lost");
  a_host_off: assert property (
    remote_mode_i && host_off_i[0] && !fail_safe_i[0] |-> ##2 !relay_o[0]) else $error("off lost");
  a_power_lost: assert property (
    (dc_fail_i && !bat_present_i)[*3] |-> power_lost_o) else $error("power loss missed");
  a_power_ok: assert property (
    (!dc_fail_i)[*3] |-> !power_lost_o) else $error("false power loss");
  a_fail_safe: assert property (
    power_lost_o && fail_safe_i[7] |-> ##[0:2] relay_o[7]) else $error("fail-safe relay off");
  a_test_pass: assert property (
    test_pass_o[0] |-> ok_a) else $error("pass outside variance");
  a_test_fail: assert property (
    test_fail_o[0] |-> !ok_a) else $error("fail within variance");
  a_change_rep: assert property (
    remote_mode_i && $changed(input_state_o) |-> ##[0:1] change_o) else $error("change unreported");
  c_pass: cover property (test_pass_o[0]);
  c_change: cover property (change_o);
  c_fail_safe: cover property (power_lost_o && relay_o[7]);
endmodule
`default_nettype wire

// ==== relay_channel.v ====
`timescale 1ns/1ns
`default_nettype none
`include "aux_relay_map.vh"
module relay_channel (
  // clock and reset
  input  wire       mclk_i,
  input  wire       srst_i,
  input  wire       tick_i,
  // control
  input  wire       remote_i,
  input  wire       local_req_i,
  input  wire [1:0] act_type_i,
  input  wire [4:0] on_steps_i,
  input  wire [4:0] off_steps_i,
  input  wire       cmd_on_i,
  input  wire       cmd_off_i,
  input  wire       fail_safe_en_i,
  input  wire       power_lost_i,
  // output
  output reg        relay_o
);
  // ***********************************
  // per-relay timing and mode sequencing
  // ***********************************
  reg       run_q;
  reg       phase_q;
  reg [4:0] cnt_q;
  reg       mode_q;
  always @(posedge mclk_i) begin
    if (srst_i) begin
      run_q   <= 1'b0;
      phase_q <= 1'b0;
      cnt_q   <= 5'h00;
      relay_o <= 1'b0;
      mode_q  <= 1'b0;
    end else begin
      mode_q <= remote_i;
      if (remote_i) begin
        if (cmd_off_i) begin
          run_q   <= 1'b0;
          phase_q <= 1'b0;
        end else if (cmd_on_i) begin
          run_q   <= 1'b1;
          phase_q <= 1'b1;
          cnt_q   <= 5'h00;
        end else if (!mode_q) begin
          // a local hold must not outlive the switch to host control
          run_q   <= 1'b0;
          phase_q <= 1'b0;
        end else if (run_q && tick_i && act_type_i != `ACT_LATCH) begin
          if (phase_q && cnt_q + 5'h01 >= on_steps_i) begin
            cnt_q   <= 5'h00;
            phase_q <= 1'b0;
            if (act_type_i == `ACT_PULSE)
              run_q <= 1'b0;
          end else if (!phase_q && cnt_q + 5'h01 >= off_steps_i) begin
            cnt_q   <= 5'h00;
            phase_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
      end else begin
        // hold time restarts while the event lasts, so it runs on after the event ends
        if (local_req_i) begin
          run_q <= 1'b1;
          cnt_q <= 5'h00;
        end else if (mode_q) begin
          run_q <= 1'b0;
        end else if (run_q && tick_i) begin
          if (cnt_q + 5'h01 >= on_steps_i)
            run_q <= 1'b0;
          else
            cnt_q <= cnt_q + 5'h01;
        end
        phase_q <= 1'b1;
      end
      relay_o <= (run_q && phase_q && !(remote_i && cmd_off_i)) ||
                 (fail_safe_en_i && power_lost_i);
    end
  end
endmodule
`default_nettype wire

// ==== relay_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module relay_host_model (
  // clock
  input  wire logic   mclk_i,
  // link to block
  input  wire logic   change_i,
  output logic [11:0] host_on_o,
  output logic [11:0] host_off_o
);
  // ****************
  // host side
  // ****************
  integer n_change = 0;
  initial begin
    host_on_o = 12'h000;
    host_off_o = 12'h000;
  end
  always @(posedge mclk_i) if (change_i) n_change = n_change + 1;
  // commands are one-cycle pulses, as the host link delivers them
  task cmd(input logic on, input integer idx);
    @(posedge mclk_i);
    #1;
    if (on) host_on_o[idx] = 1'h1;
    else host_off_o[idx] = 1'h1;
    @(posedge mclk_i);
    #1;
    host_on_o = 12'h000;
    host_off_o = 12'h000;
  endtask
endmodule
`default_nettype wire
